// ==== hdl/cdf_engine.sv ====
// Descriptor engine for the cross-domain fill and compare operations.
// Assumes memory, permission table and descriptor source share clk.
`timescale 1ns/10ps
`include "cdf_map.svh"

module cdf_engine import cdf_pkg::*; (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Descriptor submission
  input  wire logic         desc_valid,
  input  wire logic [511:0] desc_data,
  output logic              desc_ready_q,
  input  wire logic         wide_pattern_capability,
  // Permission table lookup
  output logic              pt_req_valid_q,
  output logic [15:0]       pt_req_handle_q,
  input  wire logic         pt_rsp_valid,
  input  wire logic [19:0]  pt_rsp_pasid,
  // Memory port
  output logic              mem_req_valid_q,
  output logic              mem_req_write_q,
  output logic [63:0]       mem_req_addr_q,
  output logic [19:0]       mem_req_pasid_q,
  output logic [63:0]       mem_req_data_q,
  output logic [3:0]        mem_req_len_q,
  input  wire logic         mem_req_ready,
  input  wire logic         mem_rsp_valid,
  input  wire logic [63:0]  mem_rsp_data,
  // Completion status
  output logic              busy_q,
  output logic              done_q,
  output logic [7:0]        done_status_q
);

  // ********************************
  // Helpers
  // ********************************
  // Bytes in the next chunk: up to eight, fewer at the tail
  function automatic logic [3:0] chunk_len(input logic [31:0] size, input logic [31:0] cnt);
    logic [31:0] rem;
    rem = size - cnt;
    chunk_len = (rem >= `CDF_CHUNK) ? 4'h8 : rem[3:0];
  endfunction : chunk_len

  // Index of the first differing byte below len, 8 when none
  function automatic logic [3:0] first_diff(input logic [63:0] a, input logic [63:0] b,
                                            input logic [3:0] len);
    first_diff = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if ((4'(i) < len) && (a[i*8 +: 8] != b[i*8 +: 8])) begin
        first_diff = 4'(i);
      end
    end
  endfunction : first_diff

  // ********************************
  // State
  // ********************************
  cdf_state_e     st_q, st_d;
  logic [511:0]   desc_q, desc_d;
  logic [31:0]    cnt_q, cnt_d;
  logic [31:0]    bc_q, bc_d;
  logic [19:0]    pas1_q, pas1_d, pas2_q, pas2_d;
  logic [63:0]    dat1_q, dat1_d;
  logic [7:0]     res_q, res_d, stat_q, stat_d;
  logic           wait_q, wait_d;
  logic           desc_ready_d, pt_v_d, mv_d, mw_d, busy_d, done_d;
  logic [15:0]    pt_h_d;
  logic [63:0]    ma_d, md_d;
  logic [19:0]    mp_d;
  logic [3:0]     ml_d;
  logic [7:0]     dst_d;
  // Decoded descriptor fields
  logic           is_fill, wide, alt1, alt2, bad_w;
  logic [31:0]    size;
  logic [3:0]     len_w, diff_w;
  logic           accepted;

  assign is_fill  = desc_q[`CDF_F_OP] == `CDF_OP_FILL;
  assign wide     = desc_q[`CDF_FL_WIDE];
  assign alt1     = desc_q[`CDF_FL_ALT1];
  assign alt2     = is_fill | desc_q[`CDF_FL_ALT2];
  assign size     = desc_q[`CDF_F_SIZE];
  assign len_w    = chunk_len(size, cnt_q);
  assign diff_w   = first_diff(dat1_q, mem_rsp_data, len_w);
  // A request stays posted until the memory port takes it
  assign accepted = wait_q & ~mem_req_valid_q;

  // Flag screening; the wide flag also needs the capability
  always_comb begin
    if (is_fill) begin
      bad_w = !desc_q[`CDF_FL_ALT2] || desc_q[`CDF_FL_ALT1] || (|desc_q[`CDF_F_RSV_FILL])
              || (wide && !wide_pattern_capability);
    end else begin
      bad_w = !(desc_q[`CDF_FL_ALT1] || desc_q[`CDF_FL_ALT2]) || (|desc_q[`CDF_F_RSV_CMP]);
    end
  end

  // ********************************
  // Sequencer next state
  // ********************************
  always_comb begin
    st_d = st_q;
    desc_d = desc_q;
    cnt_d = cnt_q;
    bc_d = bc_q;
    pas1_d = pas1_q;
    pas2_d = pas2_q;
    dat1_d = dat1_q;
    res_d = res_q;
    stat_d = stat_q;
    wait_d = wait_q;
    desc_ready_d = desc_ready_q;
    pt_v_d = 1'b0;
    pt_h_d = pt_req_handle_q;
    mv_d = mem_req_valid_q & ~mem_req_ready;
    mw_d = mem_req_write_q;
    ma_d = mem_req_addr_q;
    mp_d = mem_req_pasid_q;
    md_d = mem_req_data_q;
    ml_d = mem_req_len_q;
    busy_d = 1'b1;
    done_d = 1'b0;
    dst_d = done_status_q;
    case (st_q)
      CDF_IDLE: begin
        busy_d = 1'b0;
        if (desc_valid && desc_ready_q) begin
          desc_d = desc_data;
          desc_ready_d = 1'b0;
          busy_d = 1'b1;
          cnt_d = 32'h0;
          bc_d = 32'h0;
          res_d = 8'h0;
          wait_d = 1'b0;
          st_d = CDF_CHECK;
        end
      end
      CDF_CHECK: begin
        stat_d = `CDF_ST_SUCCESS;
        if (!is_fill && desc_q[`CDF_F_OP] != `CDF_OP_CMP) begin
          stat_d = `CDF_ST_BAD_OP;
          st_d = CDF_CR0;
        end else if (bad_w) begin
          stat_d = `CDF_ST_BAD_FLAG;
          st_d = CDF_CR0;
        end else begin
          st_d = CDF_LOOK1;
        end
      end
      // Source1 PASID: table entry or the descriptor's own
      CDF_LOOK1: begin
        if (is_fill || !alt1) begin
          pas1_d = desc_q[`CDF_F_PASID];
          st_d = CDF_LOOK2;
        end else if (!wait_q) begin
          pt_v_d = 1'b1;
          pt_h_d = desc_q[`CDF_F_HANDLE1];
          wait_d = 1'b1;
        end else if (pt_rsp_valid) begin
          pas1_d = pt_rsp_pasid;
          wait_d = 1'b0;
          st_d = CDF_LOOK2;
        end
      end
      // Source2 or destination PASID; both share the last handle field
      CDF_LOOK2: begin
        if (!alt2 || (wait_q && pt_rsp_valid)) begin
          pas2_d = alt2 ? pt_rsp_pasid : desc_q[`CDF_F_PASID];
          wait_d = 1'b0;
          if (size == 32'h0) begin
            st_d = CDF_CR0;
          end else begin
            st_d = is_fill ? CDF_WR : CDF_RD1;
          end
        end else if (!wait_q) begin
          pt_v_d = 1'b1;
          pt_h_d = desc_q[`CDF_F_HANDLE2];
          wait_d = 1'b1;
        end
      end
      // Read a chunk of source1 and hold it for the comparison
      CDF_RD1: begin
        if (!wait_q) begin
          mv_d = 1'b1;
          mw_d = 1'b0;
          ma_d = desc_q[`CDF_F_ADDR1] + {32'h0, cnt_q};
          mp_d = pas1_q;
          ml_d = len_w;
          wait_d = 1'b1;
        end else if (accepted && mem_rsp_valid) begin
          dat1_d = mem_rsp_data;
          wait_d = 1'b0;
          st_d = CDF_RD2;
        end
      end
      // Read source2; stop at the first mismatching byte
      CDF_RD2: begin
        if (!wait_q) begin
          mv_d = 1'b1;
          mw_d = 1'b0;
          ma_d = desc_q[`CDF_F_ADDR2] + {32'h0, cnt_q};
          mp_d = pas2_q;
          ml_d = len_w;
          wait_d = 1'b1;
        end else if (accepted && mem_rsp_valid) begin
          wait_d = 1'b0;
          if (diff_w != 4'h8) begin
            res_d = 8'h01;
            bc_d = cnt_q + {28'h0, diff_w};
            st_d = CDF_CR0;
          end else if (cnt_q + {28'h0, len_w} >= size) begin
            st_d = CDF_CR0;
          end else begin
            cnt_d = cnt_q + {28'h0, len_w};
            st_d = CDF_RD1;
          end
        end
      end
      // Fill; a wide pattern alternates halves by chunk parity
      CDF_WR: begin
        if (!mem_req_valid_q || mem_req_ready) begin
          if (cnt_q >= size) begin
            bc_d = cnt_q;
            st_d = CDF_CR0;
          end else begin
            mv_d = 1'b1;
            mw_d = 1'b1;
            ma_d = desc_q[`CDF_F_ADDR2] + {32'h0, cnt_q};
            mp_d = pas2_q;
            md_d = (wide && cnt_q[3]) ? desc_q[`CDF_F_UPPER] : desc_q[`CDF_F_ADDR1];
            ml_d = len_w;
            cnt_d = cnt_q + {28'h0, len_w};
          end
        end
      end
      // Completion record: status quadword, fault address, fault handle
      CDF_CR0, CDF_CR1, CDF_CR2: begin
        if (!wait_q) begin
          mv_d = 1'b1;
          mw_d = 1'b1;
          mp_d = desc_q[`CDF_F_PASID];
          ml_d = 4'h8;
          md_d = 64'h0;
          wait_d = 1'b1;
          ma_d = desc_q[`CDF_F_CMPL];
          if (st_q == CDF_CR0) begin
            // Check-result turns a mismatch with expectation into a false predicate
            if (!is_fill && stat_q == `CDF_ST_SUCCESS && desc_q[`CDF_FL_CHECK]
                && res_q[0] != desc_q[`CDF_F_EXPECT]) begin
              stat_d = `CDF_ST_FALSE;
            end
            md_d = {bc_q, 16'h0, is_fill ? 8'h0 : res_q, stat_d};
          end else if (st_q == CDF_CR1) begin
            ma_d = desc_q[`CDF_F_CMPL] + `CDF_REC_QW1;
          end else begin
            ma_d = desc_q[`CDF_F_CMPL] + `CDF_REC_QW2;
          end
        end else if (accepted) begin
          wait_d = 1'b0;
          if (st_q == CDF_CR0) begin
            st_d = CDF_CR1;
          end else if (st_q == CDF_CR1 && !is_fill && stat_q != `CDF_ST_BAD_OP) begin
            st_d = CDF_CR2;
          end else begin
            st_d = CDF_DONE;
          end
        end
      end
      CDF_DONE: begin
        done_d = 1'b1;
        dst_d = stat_q;
        desc_ready_d = 1'b1;
        busy_d = 1'b0;
        st_d = CDF_IDLE;
      end
      default: begin
        st_d = CDF_IDLE;
      end
    endcase
  end

  // ********************************
  // Sequencer registers
  // ********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= CDF_IDLE;
      desc_q <= '0;
      cnt_q <= 32'h0;
      bc_q <= 32'h0;
      pas1_q <= 20'h0;
      pas2_q <= 20'h0;
      dat1_q <= 64'h0;
      res_q <= 8'h0;
      stat_q <= 8'h0;
      wait_q <= 1'b0;
      desc_ready_q <= 1'b1;
      pt_req_valid_q <= 1'b0;
      pt_req_handle_q <= 16'h0;
      mem_req_valid_q <= 1'b0;
      mem_req_write_q <= 1'b0;
      mem_req_addr_q <= 64'h0;
      mem_req_pasid_q <= 20'h0;
      mem_req_data_q <= 64'h0;
      mem_req_len_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      done_status_q <= 8'h0;
    end else begin
      st_q <= st_d;
      desc_q <= desc_d;
      cnt_q <= cnt_d;
      bc_q <= bc_d;
      pas1_q <= pas1_d;
      pas2_q <= pas2_d;
      dat1_q <= dat1_d;
      res_q <= res_d;
      stat_q <= stat_d;
      wait_q <= wait_d;
      desc_ready_q <= desc_ready_d;
      pt_req_valid_q <= pt_v_d;
      pt_req_handle_q <= pt_h_d;
      mem_req_valid_q <= mv_d;
      mem_req_write_q <= mw_d;
      mem_req_addr_q <= ma_d;
      mem_req_pasid_q <= mp_d;
      mem_req_data_q <= md_d;
      mem_req_len_q <= ml_d;
      busy_q <= busy_d;
      done_q <= done_d;
      done_status_q <= dst_d;
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fill_writes_a: assert property ((st_q == CDF_WR) && mv_d && !(mem_req_valid_q && !mem_req_ready)
    |=> mem_req_write_q && mem_req_pasid_q == pas2_q) else $error("fill request not a write");
  narrow_pattern_a: assert property (mem_req_valid_q && mem_req_write_q && is_fill && !wide
    && $past(st_q) == CDF_WR |-> mem_req_data_q == desc_q[`CDF_F_ADDR1])
    else $error("narrow fill data wrong");
  wide_pattern_a: assert property (mem_req_valid_q && is_fill && wide && $past(st_q) == CDF_WR
    && ((mem_req_addr_q - desc_q[`CDF_F_ADDR2]) & 64'h8) != 64'h0 |-> mem_req_data_q == desc_q[`CDF_F_UPPER])
    else $error("wide fill upper half wrong");
  cmp_reads_a: assert property ($rose(mem_req_valid_q) && $past(st_q) == CDF_RD1
    |-> !mem_req_write_q && mem_req_addr_q == desc_q[`CDF_F_ADDR1] + {32'h0, cnt_q})
    else $error("source1 read wrong");
  src2_pasid_a: assert property ($rose(mem_req_valid_q) && $past(st_q) == CDF_RD2 && alt2
    |-> mem_req_pasid_q == pas2_q) else $error("source2 pasid wrong");
  src1_table_a: assert property (st_q == CDF_LOOK1 && alt1 && !is_fill && wait_q && pt_rsp_valid
    |=> pas1_q == $past(pt_rsp_pasid)) else $error("source1 pasid not from table");
  own_pasid_a: assert property ($rose(mem_req_valid_q) && $past(st_q) == CDF_RD1 && !alt1
    |-> mem_req_pasid_q == desc_q[`CDF_F_PASID]) else $error("own pasid not used");
  bad_flags_a: assert property (st_q == CDF_CHECK && bad_w && (is_fill || desc_q[`CDF_F_OP] == `CDF_OP_CMP)
    |=> st_q == CDF_CR0 && stat_q == `CDF_ST_BAD_FLAG && !mem_req_valid_q && !pt_req_valid_q)
    else $error("bad flags not rejected");
  fault_addr_a: assert property ($rose(mem_req_valid_q) && $past(st_q) == CDF_CR1
    |-> mem_req_addr_q == desc_q[`CDF_F_CMPL] + `CDF_REC_QW1 && mem_req_data_q == 64'h0)
    else $error("record quadword 1 wrong");
  done_status_a: assert property (st_q == CDF_DONE |=> done_q && done_status_q == $past(stat_q)
    ##1 !done_q) else $error("done status wrong");

  fill_done_c: cover property (st_q == CDF_WR ##[1:200] done_q && done_status_q == `CDF_ST_SUCCESS);
  cmp_miss_c: cover property (st_q == CDF_RD2 && res_d == 8'h01 && res_q == 8'h0);
  bad_flag_c: cover property (done_q && done_status_q == `CDF_ST_BAD_FLAG);
  false_pred_c: cover property (done_q && done_status_q == `CDF_ST_FALSE);

endmodule : cdf_engine

// ==== hdl/cdf_map.svh ====
// Descriptor field positions, flag bits, status codes and record offsets
// for the cross-domain fill and compare engine. Assumes a 512-bit
// descriptor image with byte 0 in bits 7:0.
`ifndef CDF_MAP_SVH
`define CDF_MAP_SVH

// ********************************
// Operation codes
// ********************************
`define CDF_OP_FILL     8'h24
`define CDF_OP_CMP      8'h25

// ********************************
// Descriptor fields (bit ranges)
// ********************************
`define CDF_F_PASID     19:0
`define CDF_F_OP        63:56
`define CDF_F_CMPL      127:64
`define CDF_F_ADDR1     191:128
`define CDF_F_ADDR2     255:192
`define CDF_F_SIZE      287:256
`define CDF_F_UPPER     383:320
`define CDF_F_EXPECT    320
`define CDF_F_HANDLE2   511:496
`define CDF_F_HANDLE1   495:480
`define CDF_F_RSV_FILL  55:51
`define CDF_F_RSV_CMP   55:50

// ********************************
// Flag bits (descriptor bit index)
// ********************************
`define CDF_FL_CHECK    35
`define CDF_FL_ALT1     48
`define CDF_FL_ALT2     49
`define CDF_FL_WIDE     50

// ********************************
// Status codes and record layout
// ********************************
`define CDF_ST_SUCCESS  8'h01
`define CDF_ST_FALSE    8'h02
`define CDF_ST_BAD_OP   8'h10
`define CDF_ST_BAD_FLAG 8'h11
`define CDF_REC_QW1     64'h0000_0000_0000_0008
`define CDF_REC_QW2     64'h0000_0000_0000_0010
`define CDF_CHUNK       32'h0000_0008

`endif

// ==== hdl/cdf_pkg.sv ====
// Types shared by the cross-domain fill and compare engine.
// Assumes the constants of cdf_map.svh are included by the user.
package cdf_pkg;

  // ********************************
  // Engine states
  // ********************************
  typedef enum logic [3:0] {
    CDF_IDLE, CDF_CHECK, CDF_LOOK1, CDF_LOOK2, CDF_RD1, CDF_RD2,
    CDF_WR, CDF_CR0, CDF_CR1, CDF_CR2, CDF_DONE
  } cdf_state_e;

endpackage : cdf_pkg

// ==== verification/cdf_engine_tb_top.sv ====
// Self-checking bench for the cross-domain fill and compare engine.
// Assumes cdf_partner_model answers memory and table traffic.
`timescale 1ns/10ps
`include "cdf_map.svh"

module cdf_engine_tb_top;
  typedef struct {logic [63:0] a; logic [63:0] d; logic [19:0] p; logic [3:0] n;} cdf_wr_s;

  logic          clk, rst, desc_valid, wide_pattern_capability, slow, desc_ready_q;
  logic [511:0]  desc_data;
  logic [63:0]   diff;
  logic          pt_req_valid_q, pt_rsp_valid, mem_req_valid_q, mem_req_write_q, mem_req_ready;
  logic          mem_rsp_valid, busy_q, done_q;
  logic [15:0]   pt_req_handle_q;
  logic [19:0]   pt_rsp_pasid, mem_req_pasid_q;
  logic [63:0]   mem_req_addr_q, mem_req_data_q, mem_rsp_data;
  logic [3:0]    mem_req_len_q;
  logic [7:0]    done_status_q;
  int            mismatches, cmp_count, looks, reads;
  cdf_wr_s       wq[$];
  logic [7:0]    sq[$];

  cdf_engine dut (.clk, .rst, .desc_valid, .desc_data, .desc_ready_q, .wide_pattern_capability,
    .pt_req_valid_q, .pt_req_handle_q, .pt_rsp_valid, .pt_rsp_pasid, .mem_req_valid_q,
    .mem_req_write_q, .mem_req_addr_q, .mem_req_pasid_q, .mem_req_data_q, .mem_req_len_q,
    .mem_req_ready, .mem_rsp_valid, .mem_rsp_data, .busy_q, .done_q, .done_status_q);

  cdf_partner_model u_far (.clk, .rst, .slow, .diff_addr(diff), .pt_req_valid_q, .pt_req_handle_q,
    .pt_rsp_valid, .pt_rsp_pasid, .mem_req_valid_q, .mem_req_write_q, .mem_req_addr_q,
    .mem_req_pasid_q, .mem_req_len_q, .mem_req_ready, .mem_rsp_valid, .mem_rsp_data);

  // ********************************
  // Checking
  // ********************************
  task chk_val(input string what, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  // Only the bytes named by the length carry data
  task chk_wr(input cdf_wr_s e);
    logic [63:0] m;
    m = 64'h0;
    for (int i = 0; i < e.n; i++) m[8*i+:8] = 8'hff;
    chk_val("write address", e.a, mem_req_addr_q);
    chk_val("write pasid", 64'(e.p), 64'(mem_req_pasid_q));
    chk_val("write length", 64'(e.n), 64'(mem_req_len_q));
    chk_val("write data", e.d & m, mem_req_data_q & m);
  endtask : chk_wr

  // Watcher: each write or completion takes the oldest note off its queue
  always @(posedge clk) begin
    if (!rst) begin
      if (pt_req_valid_q) looks++;
      if (mem_req_valid_q && mem_req_ready) begin
        if (!mem_req_write_q) reads++;
        else if (wq.size() == 0) chk_val("extra write", 64'h0, mem_req_addr_q);
        else chk_wr(wq.pop_front());
      end
      if (done_q) begin
        chk_val("idle at done", 64'h1, 64'({busy_q, desc_ready_q}));
        if (sq.size() != 0) chk_val("status", 64'(sq.pop_front()), 64'(done_status_q));
        else chk_val("extra done", 64'h0, 64'h1);
      end
    end
  end

  // ********************************
  // Driving
  // ********************************
  task exp_wr(input logic [63:0] a, input logic [63:0] d, input logic [19:0] p, input logic [3:0] n);
    wq.push_back('{a, d, p, n});
  endtask : exp_wr

  // Record: status, result, bytes completed, then zeroed fault words
  task exp_rec(input logic [63:0] c, input logic [19:0] p, input logic [31:0] bc, input logic [7:0] res,
               input logic [7:0] st, input int nq);
    exp_wr(c, {bc, 16'h0, res, st}, p, 4'h8);
    for (int i = 1; i < nq; i++) exp_wr(c + 64'(8 * i), 64'h0, p, 4'h8);
  endtask : exp_rec

  function automatic logic [63:0] hdr(input logic [7:0] op, input logic [7:0] fl, input logic ck,
                                      input logic [19:0] pa);
    return {op, fl, 12'h0, ck, 3'h0, 12'h0, pa};
  endfunction : hdr

  // Offer one descriptor, wait for its completion, then check side traffic
  task send(input logic [511:0] d, input logic [7:0] st, input int nl, input int nr);
    int n;
    looks = 0;
    reads = 0;
    sq.push_back(st);
    @(posedge clk);
    #1 desc_data = d;
    desc_valid = 1'b1;
    n = 0;
    do @(posedge clk); while (desc_ready_q !== 1'b1 && ++n < 500);
    #1 desc_valid = 1'b0;
    // Taken at the last edge: engine busy and closed to new work
    chk_val("busy after take", 64'h2, 64'({busy_q, desc_ready_q}));
    n = 0;
    while (sq.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    // Step off the edge so the next test's inputs never race the clock
    #1;
    chk_val("pending", 64'h0, 64'(sq.size() + wq.size()));
    chk_val("lookups", 64'(nl), 64'(looks));
    chk_val("reads", 64'(nr), 64'(reads));
    wq.delete();
    $display("test done, status %h", st);
  endtask : send

  task fill(input logic [7:0] op, input logic [7:0] fl, input logic ck);
    logic [63:0] lo, up, dst, cm;
    logic [31:0] sz;
    logic [19:0] pa, pd;
    logic [15:0] h;
    logic        bad;
    lo = {$urandom, $urandom};
    up = {$urandom, $urandom};
    dst = {32'h0, $urandom};
    cm = {32'h1, $urandom};
    sz = 1 + $urandom % 40;
    pa = 20'($urandom);
    h = 16'($urandom);
    wide_pattern_capability = ck;
    pd = {12'h0a5, h[7:0] ^ 8'h5a};
    bad = !fl[1] || fl[0] || |fl[7:3] || (fl[2] && !ck);
    if (op != `CDF_OP_FILL) exp_rec(cm, pa, 32'h0, 8'h0, `CDF_ST_BAD_OP, 2);
    else if (bad) exp_rec(cm, pa, 32'h0, 8'h0, `CDF_ST_BAD_FLAG, 2);
    else begin
      for (int o = 0; o < sz; o += 8)
        exp_wr(dst + 64'(o), (fl[2] && o[3]) ? up : lo, pd, (sz - o > 8) ? 4'h8 : 4'(sz - o));
      exp_rec(cm, pa, sz, 8'h0, `CDF_ST_SUCCESS, 2);
    end
    send({h, 112'h0, up, 32'h0, sz, dst, lo, cm, hdr(op, fl, 1'b0, pa)}, op != `CDF_OP_FILL ?
         `CDF_ST_BAD_OP : bad ? `CDF_ST_BAD_FLAG : `CDF_ST_SUCCESS, (op == `CDF_OP_FILL && !bad) ? 1 : 0, 0);
  endtask : fill

  task cmp(input logic [7:0] fl, input logic dif, input logic ck, input logic ev);
    logic [63:0] a1, a2, cm;
    logic [31:0] sz, d0;
    logic [19:0] pa, p1, p2;
    logic [15:0] h1, h2;
    logic        bad;
    logic [7:0]  st;
    a1 = {32'h0, $urandom};
    a2 = {32'h0, $urandom};
    cm = {32'h1, $urandom};
    sz = 1 + $urandom % 40;
    d0 = $urandom % sz;
    pa = 20'($urandom);
    h1 = 16'($urandom);
    h2 = 16'($urandom);
    p1 = fl[0] ? {12'h0a5, h1[7:0] ^ 8'h5a} : pa;
    p2 = fl[1] ? {12'h0a5, h2[7:0] ^ 8'h5a} : pa;
    a2[7:0] = a1[7:0] + p1[7:0] - p2[7:0];
    diff = dif ? a2 + 64'(d0) : '1;
    bad = !(fl[0] || fl[1]) || |fl[7:2];
    st = bad ? `CDF_ST_BAD_FLAG : (ck && dif != ev) ? `CDF_ST_FALSE : `CDF_ST_SUCCESS;
    exp_rec(cm, pa, (bad || !dif) ? 32'h0 : d0, bad ? 8'h0 : {7'h0, dif}, st, 3);
    send({h2, h1, 96'h0, 63'h0, ev, 32'h0, sz, a2, a1, cm, hdr(`CDF_OP_CMP, fl, ck, pa)}, st,
         bad ? 0 : int'(fl[0]) + int'(fl[1]), bad ? 0 : 2 * (dif ? d0 / 8 + 1 : (sz + 7) / 8));
  endtask : cmp

  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // ********************************
  // Sequence
  // ********************************
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  // Watchdog, well beyond the expected run of a few thousand cycles
  initial begin
    #400000;
    mismatches++;
    wrap_up;
  end

  // Two passes: the first with a prompt far side, the second with a slow one
  initial begin
    rst = 0;
    desc_valid = 0;
    desc_data = '0;
    wide_pattern_capability = 0;
    slow = 0;
    diff = '1;
    void'($urandom(66));
    #1 rst = 1;
    repeat (20) @(posedge clk);
    #1 rst = 0;
    for (int s = 0; s < 2; s++) begin
      slow = 1'(s);
      diff = '1;
      fill(`CDF_OP_FILL, 8'h02, 1'b0);
      fill(`CDF_OP_FILL, 8'h06, 1'b1);
      fill(`CDF_OP_FILL, 8'h06, 1'b0);
      fill(`CDF_OP_FILL, 8'h00, 1'b1);
      fill(`CDF_OP_FILL, 8'h03, 1'b1);
      fill(`CDF_OP_FILL, 8'h0a, 1'b1);
      fill(8'h30, 8'h02, 1'b1);
      for (int f = 1; f < 4; f++)
        for (int k = 0; k < 4; k++) cmp(8'(f), k[0], k[1], 1'($urandom));
      cmp(8'h00, 1'b0, 1'b0, 1'b0);
      cmp(8'h07, 1'b1, 1'b1, 1'b0);
    end
    wrap_up;
  end
endmodule : cdf_engine_tb_top

// ==== verification/cdf_partner_model.sv ====
// Behavioural far side of the fill and compare engine: memory and permission table.
// Assumes the bench drives slow and diff_addr; all traffic moves on the rising edge of clk.
`timescale 1ns/10ps

module cdf_partner_model (
  // Clock, reset and mode
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [63:0] diff_addr,
  // Permission table
  input  wire logic        pt_req_valid_q,
  input  wire logic [15:0] pt_req_handle_q,
  output logic             pt_rsp_valid,
  output logic [19:0]      pt_rsp_pasid,
  // Memory
  input  wire logic        mem_req_valid_q,
  input  wire logic        mem_req_write_q,
  input  wire logic [63:0] mem_req_addr_q,
  input  wire logic [19:0] mem_req_pasid_q,
  input  wire logic [3:0]  mem_req_len_q,
  output logic             mem_req_ready,
  output logic             mem_rsp_valid,
  output logic [63:0]      mem_rsp_data
);
  int          mwait;
  int          twait;
  logic [63:0] rdata;
  logic [19:0] tpas;
  logic [7:0]  b;

  // ********************************
  // Answers
  // ********************************
  // A byte reads as address plus PASID, so a wrong PASID shows up as a miscompare.
  // Idle answer lines carry noise, never the last value.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_req_ready <= 1'b0;
      mem_rsp_valid <= 1'b0;
      pt_rsp_valid  <= 1'b0;
      mwait = 0;
      twait = 0;
    end else begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_data  <= {$urandom, $urandom};
      pt_rsp_valid  <= 1'b0;
      pt_rsp_pasid  <= 20'($urandom);
      if (mwait > 0) begin
        mwait--;
        if (mwait == 0) begin
          mem_rsp_valid <= 1'b1;
          mem_rsp_data  <= rdata;
        end
      end
      if (twait > 0) begin
        twait--;
        if (twait == 0) begin
          pt_rsp_valid <= 1'b1;
          pt_rsp_pasid <= tpas;
        end
      end
      // Every handle names a usable entry of the permission table
      if (pt_req_valid_q) begin
        twait = slow ? 1 + $urandom % 4 : 1;
        tpas = {12'h0a5, pt_req_handle_q[7:0] ^ 8'h5a};
      end
      if (mem_req_valid_q && mem_req_ready && !mem_req_write_q) begin
        mwait = slow ? 1 + $urandom % 4 : 1;
        for (int i = 0; i < 8; i++) begin
          b = mem_req_addr_q[7:0] + 8'(i) + mem_req_pasid_q[7:0];
          if (mem_req_addr_q + 64'(i) == diff_addr || i >= mem_req_len_q) b = ~b;
          rdata[8*i+:8] = b;
        end
      end
      mem_req_ready <= slow ? 1'($urandom) : 1'b1;
    end
  end
endmodule : cdf_partner_model
